// >>> hdl/uip_prioritizer.sv
/*
 Interrupt enable, line status and prioritised interrupt status of a
 single-channel UART, on the device's parallel register bus.
 Assumes read and write strobes are one-cycle pulses already on mclk,
 and FIFO levels, events and error flags come from the UART core.
*/
`timescale 1ns/1ns
module uip_prioritizer #(
   parameter int LVL_W = 5
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Register bus
   input wire logic [2:0] addr,
   input wire logic rdStb,
   input wire logic wrStb,
   input wire logic [7:0] wrData,
   output logic [7:0] rdData,
   // Register context
   input wire logic divLatch,
   input wire logic enhEnable,
   input wire logic fifoEnable,
   input wire logic [1:0] rxTrigSel,
   input wire logic [1:0] txTrigSel,
   // Receive side
   input wire logic [LVL_W-1:0] rxLevel,
   input wire logic rxDataPresent,
   input wire logic rxCharEvt,
   input wire logic overrunEvt,
   input wire logic [2:0] headErr,
   input wire logic errPopEvt,
   input wire logic fifoErrAny,
   input wire logic bitTick,
   input wire logic [3:0] charBits,
   // Transmit side
   input wire logic [LVL_W-1:0] txLevel,
   input wire logic thrEmpty,
   input wire logic txAllEmpty,
   // Modem and flow control
   input wire logic [3:0] msrDelta,
   input wire logic xoffEvt,
   input wire logic xonEvt,
   input wire logic specialEvt,
   input wire logic ctsRtsEvt,
   input wire logic wakeEvt,
   // Outputs
   output logic irq,
   output logic sleepEnable,
   output logic pollMode
);
   // ==========================================
   // Bus decode
   logic regSel;
   logic ierWr;
   logic thrWr;
   logic rhrRd;
   logic isrRd;
   logic lsrRd;
   logic msrRd;
   assign regSel = ~divLatch;
   assign ierWr = wrStb & regSel & (addr == uip_pkg::ADDR_IER);
   assign thrWr = wrStb & regSel & (addr == uip_pkg::ADDR_DATA);
   assign rhrRd = rdStb & regSel & (addr == uip_pkg::ADDR_DATA);
   assign isrRd = rdStb & (addr == uip_pkg::ADDR_ISR);
   assign lsrRd = rdStb & (addr == uip_pkg::ADDR_LSR);
   assign msrRd = rdStb & (addr == uip_pkg::ADDR_MSR);

   // ==========================================
   // Interrupt enable register
   logic [7:0] ier_reg;
   logic [7:0] ier_next;
   logic [7:0] ierMask;
   assign ierMask = enhEnable ? 8'hFF : ~uip_pkg::IER_ENH_MASK;
   assign ier_next = (wrData & ierMask) | (ier_reg & ~ierMask);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ier_reg <= uip_pkg::IER_RESET;
      end else if (ierWr) begin
         ier_reg <= ier_next;
      end
   end

   assign sleepEnable = ier_reg[uip_pkg::IER_SLEEP];
   assign pollMode = fifoEnable & (ier_reg[3:0] == 4'h0);

   // ==========================================
   // Trigger levels
   logic [4:0] rxTrig;
   logic [4:0] txTrig;
   assign rxTrig = (rxTrigSel == 2'h0) ? uip_pkg::TRIG_0 :
                   (rxTrigSel == 2'h1) ? uip_pkg::TRIG_1 :
                   (rxTrigSel == 2'h2) ? uip_pkg::TRIG_2 : uip_pkg::TRIG_3;
   assign txTrig = (txTrigSel == 2'h0) ? uip_pkg::TRIG_0 :
                   (txTrigSel == 2'h1) ? uip_pkg::TRIG_1 :
                   (txTrigSel == 2'h2) ? uip_pkg::TRIG_2 : uip_pkg::TRIG_3;

   // ==========================================
   // Receive ready: a level, drops as reads take the FIFO below trigger
   logic rxCond;
   assign rxCond = fifoEnable ? (5'(rxLevel) >= rxTrig) : rxDataPresent;

   // ==========================================
   // Receive time-out
   logic [6:0] toLimit;
   logic toExpire;
   logic toFlag;
   assign toLimit = uip_pkg::TO_CHARS * 7'(charBits) + uip_pkg::TO_EXTRA_BITS;

   uip_timeout #(
      .CNT_W(7)
   ) u_timeout (
      .mclk(mclk),
      .rstn(rstn),
      .bitTick(bitTick),
      .run(fifoEnable & rxDataPresent),
      .restart(rxCharEvt | rhrRd),
      .limit(toLimit),
      .expire(toExpire)
   );

   uip_flag u_toFlag (
      .mclk(mclk),
      .rstn(rstn),
      .setEvt(toExpire),
      .clrEvt(rhrRd),
      .flag(toFlag)
   );

   // ==========================================
   // Line status
   logic overrunFlag;
   logic lsFlag;

   uip_flag u_overrun (
      .mclk(mclk),
      .rstn(rstn),
      .setEvt(overrunEvt),
      .clrEvt(lsrRd),
      .flag(overrunFlag)
   );

   // Overrun at reception, other errors when popped
   uip_flag u_lsFlag (
      .mclk(mclk),
      .rstn(rstn),
      .setEvt(overrunEvt | errPopEvt),
      .clrEvt(lsrRd),
      .flag(lsFlag)
   );

   logic [7:0] lsrVal;
   assign lsrVal = {fifoErrAny & fifoEnable, txAllEmpty, thrEmpty, headErr,
                    overrunFlag, rxDataPresent};

   // ==========================================
   // Transmit ready: raised on entering the empty/below-trigger state
   logic txCond;
   logic txCondPrev_reg;
   logic txSet;
   logic txFlag;
   logic txEnRise;
   assign txCond = fifoEnable ? (5'(txLevel) < txTrig) | (txLevel == '0) : thrEmpty;
   assign txEnRise = ierWr & ~ier_reg[uip_pkg::IER_TX] & ier_next[uip_pkg::IER_TX];
   assign txSet = (txCond & ~txCondPrev_reg) | (txEnRise & txCond);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         txCondPrev_reg <= 1'b0;
      end else begin
         txCondPrev_reg <= txCond;
      end
   end

   // ==========================================
   // Modem status change
   logic msAny;
   logic msPrev_reg;
   logic msFlag;
   assign msAny = |msrDelta;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         msPrev_reg <= 1'b0;
      end else begin
         msPrev_reg <= msAny;
      end
   end

   uip_flag u_msFlag (
      .mclk(mclk),
      .rstn(rstn),
      .setEvt(msAny & ~msPrev_reg),
      .clrEvt(msrRd),
      .flag(msFlag)
   );

   // ==========================================
   // Priority encode
   logic lsP;
   logic toP;
   logic rxP;
   logic txP;
   logic msP;
   logic xoP;
   logic xoffFlag;
   logic specFlag;
   logic ctsFlag;
   logic wakeFlag;
   logic anyPend;
   logic [4:0] code;
   logic [7:0] isrVal;
   assign lsP = ier_reg[uip_pkg::IER_LS] & lsFlag;
   assign toP = ier_reg[uip_pkg::IER_RX] & toFlag;
   assign rxP = ier_reg[uip_pkg::IER_RX] & rxCond;
   assign txP = ier_reg[uip_pkg::IER_TX] & txFlag;
   assign msP = ier_reg[uip_pkg::IER_MS] & msFlag;
   assign xoP = enhEnable & ier_reg[uip_pkg::IER_XOFF] &
                (xoffFlag | specFlag | ctsFlag);
   assign anyPend = lsP | toP | rxP | txP | msP | xoP;
   assign code = lsP ? uip_pkg::CODE_LS :
                 toP ? uip_pkg::CODE_TO :
                 rxP ? uip_pkg::CODE_RX :
                 txP ? uip_pkg::CODE_TX :
                 msP ? uip_pkg::CODE_MS :
                 xoP ? uip_pkg::CODE_XO : uip_pkg::CODE_NONE;
   assign isrVal = {{2{fifoEnable}}, enhEnable & ctsFlag, code};

   // ==========================================
   // Clears by status read act on the reported source, or on wake when none is pending
   logic isrTx;
   logic isrXo;
   logic isrWake;
   assign isrTx = isrRd & ~lsP & ~toP & ~rxP & txP;
   assign isrXo = isrRd & ~anyPend ? 1'b0 : isrRd & (code == uip_pkg::CODE_XO);
   assign isrWake = isrRd & ~anyPend;

   uip_flag u_txFlag (
      .mclk(mclk),
      .rstn(rstn),
      .setEvt(txSet),
      .clrEvt(isrTx | thrWr),
      .flag(txFlag)
   );

   uip_flag u_xoffFlag (
      .mclk(mclk),
      .rstn(rstn),
      .setEvt(xoffEvt),
      .clrEvt(isrXo | xonEvt),
      .flag(xoffFlag)
   );

   // Next character clears it; the setting character itself does not
   uip_flag u_specFlag (
      .mclk(mclk),
      .rstn(rstn),
      .setEvt(specialEvt),
      .clrEvt(isrXo | (rxCharEvt & ~specialEvt)),
      .flag(specFlag)
   );

   uip_flag u_ctsFlag (
      .mclk(mclk),
      .rstn(rstn),
      .setEvt(ctsRtsEvt),
      .clrEvt(isrXo),
      .flag(ctsFlag)
   );

   uip_flag u_wakeFlag (
      .mclk(mclk),
      .rstn(rstn),
      .setEvt(wakeEvt),
      .clrEvt(isrWake),
      .flag(wakeFlag)
   );

   // ==========================================
   // Read data and request output
   logic [7:0] rdMux;
   logic [7:0] rdData_reg;
   logic irq_reg;
   assign rdMux = (addr == uip_pkg::ADDR_IER && regSel) ? ier_reg :
                  (addr == uip_pkg::ADDR_ISR) ? isrVal :
                  (addr == uip_pkg::ADDR_LSR) ? lsrVal : 8'h00;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdData_reg <= 8'h00;
      end else if (rdStb) begin
         rdData_reg <= rdMux;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= anyPend | wakeFlag;
      end
   end

   assign rdData = rdData_reg;
   assign irq = irq_reg;

   // ==========================================
   // Checks
   sequence isrRead;
      rdStb && addr == uip_pkg::ADDR_ISR;
   endsequence

   ier_reset_a: assert property (@(posedge mclk)
      !rstn |=> ier_reg == 8'h00) else $error("enables not zero after reset");
   ier_lock_a: assert property (@(posedge mclk) disable iff (!rstn)
      ierWr && !enhEnable |=> ier_reg[7:4] == $past(ier_reg[7:4]))
      else $error("enhanced enable bits written while locked");
   poll_mode_a: assert property (@(posedge mclk) disable iff (!rstn)
      pollMode == (fifoEnable && ier_reg[3:0] == 4'h0)) else $error("poll mode wrong");
   ls_code_a: assert property (@(posedge mclk) disable iff (!rstn)
      lsP |-> isrVal[4:0] == 5'h06) else $error("line status not top");
   to_code_a: assert property (@(posedge mclk) disable iff (!rstn)
      !lsP && toP |-> isrVal[4:0] == 5'h0C) else $error("time-out code wrong");
   tx_code_a: assert property (@(posedge mclk) disable iff (!rstn)
      !lsP && !toP && !rxP && txP |-> isrVal[4:0] == 5'h02) else $error("tx code wrong");
   idle_code_a: assert property (@(posedge mclk) disable iff (!rstn)
      isrVal[0] == !anyPend) else $error("status bit 0 wrong");
   fifo_bits_a: assert property (@(posedge mclk) disable iff (!rstn)
      isrVal[7:6] == {2{fifoEnable}}) else $error("FIFO status bits wrong");
   isr_read_a: assert property (@(posedge mclk) disable iff (!rstn)
      isrRead |=> rdData == $past(isrVal)) else $error("status read data wrong");
   tx_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
      thrWr && !txSet |=> !txFlag) else $error("tx ready not cleared by write");
   tx_enable_a: assert property (@(posedge mclk) disable iff (!rstn)
      txEnRise && txCond |=> txFlag && txP) else $error("enable did not raise tx");
   overrun_now_a: assert property (@(posedge mclk) disable iff (!rstn)
      overrunEvt && ier_reg[2] && !ierWr |=> lsP ##1 irq)
      else $error("overrun interrupt late");
   ls_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
      lsrRd && !overrunEvt && !errPopEvt |=> !lsFlag) else $error("line status not cleared");
   irq_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
      anyPend |=> irq) else $error("request output missing");
   ms_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
      msrRd && !(msAny && !msPrev_reg) |=> !msFlag) else $error("modem flag kept");
endmodule : uip_prioritizer

// >>> hdl/uip_pkg.sv
/*
 Constants for the UART interrupt enable, status and priority block:
 register addresses, field positions, status codes, timing counts.
 Assumes a 3-bit parallel register address as on the device pins.
*/
package uip_pkg;
   // ==========================================
   // Register addresses
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_IER = 3'h1;
   localparam logic [2:0] ADDR_ISR = 3'h2;
   localparam logic [2:0] ADDR_LSR = 3'h5;
   localparam logic [2:0] ADDR_MSR = 3'h6;
   // ==========================================
   // Enable register fields and reset
   localparam int IER_RX = 0;
   localparam int IER_TX = 1;
   localparam int IER_LS = 2;
   localparam int IER_MS = 3;
   localparam int IER_SLEEP = 4;
   localparam int IER_XOFF = 5;
   localparam logic [7:0] IER_RESET = 8'h00;
   localparam logic [7:0] IER_ENH_MASK = 8'hF0;
   // ==========================================
   // Status codes, bits 4..0; bit 5 is the flow-control flag
   localparam logic [4:0] CODE_LS = 5'h06;
   localparam logic [4:0] CODE_TO = 5'h0C;
   localparam logic [4:0] CODE_RX = 5'h04;
   localparam logic [4:0] CODE_TX = 5'h02;
   localparam logic [4:0] CODE_MS = 5'h00;
   localparam logic [4:0] CODE_XO = 5'h10;
   localparam logic [4:0] CODE_NONE = 5'h01;
   // ==========================================
   // FIFO trigger levels by select code
   localparam logic [4:0] TRIG_0 = 5'h01;
   localparam logic [4:0] TRIG_1 = 5'h04;
   localparam logic [4:0] TRIG_2 = 5'h08;
   localparam logic [4:0] TRIG_3 = 5'h0E;
   // ==========================================
   // Receive time-out: characters plus bits, counted in bit ticks
   localparam logic [6:0] TO_CHARS = 7'h04;
   localparam logic [6:0] TO_EXTRA_BITS = 7'h0C;
endpackage : uip_pkg

// >>> hdl/uip_flag.sv
/*
 Sticky event flag: a set pulse raises it, a clear pulse drops it.
 Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
module uip_flag (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Events
   input wire logic setEvt,
   input wire logic clrEvt,
   // State
   output logic flag
);
   logic flag_reg;
   logic flag_next;

   // Set wins over a clear in the same cycle
   assign flag_next = setEvt | (flag_reg & ~clrEvt);
   assign flag = flag_reg;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   set_wins_a: assert property (@(posedge mclk) disable iff (!rstn)
      setEvt |=> flag) else $error("flag lost a set");
   clr_drops_a: assert property (@(posedge mclk) disable iff (!rstn)
      clrEvt && !setEvt |=> !flag) else $error("flag survived a clear");
endmodule : uip_flag

// >>> hdl/uip_timeout.sv
/*
 Receive time-out timer counted in bit-time enable pulses.
 Assumes bitTick is a one-cycle pulse per bit time from the baud divider.
*/
`timescale 1ns/1ns
module uip_timeout #(
   parameter int CNT_W = 7
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Control
   input wire logic bitTick,
   input wire logic run,
   input wire logic restart,
   input wire logic [CNT_W-1:0] limit,
   // Result
   output logic expire
);
   logic [CNT_W-1:0] cnt_reg;
   logic fired_reg;
   logic hit;

   assign hit = run & ~fired_reg & bitTick & (cnt_reg == limit - 1'b1);
   assign expire = hit;

   always_ff @(posedge mclk) begin
      if (!rstn || restart || !run) begin
         cnt_reg <= '0;
      end else if (bitTick && !fired_reg) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // One expiry per idle period
   always_ff @(posedge mclk) begin
      if (!rstn || restart || !run) begin
         fired_reg <= 1'b0;
      end else if (hit) begin
         fired_reg <= 1'b1;
      end
   end

   expire_count_a: assert property (@(posedge mclk) disable iff (!rstn)
      expire |-> cnt_reg == limit - 1'b1 && bitTick) else $error("early expiry");
   expire_once_a: assert property (@(posedge mclk) disable iff (!rstn)
      expire && !restart |=> !expire) else $error("repeated expiry");
endmodule : uip_timeout

// >>> tb/uip_host_model.sv
/*
 Host processor model on the parallel register bus of the prioritizer.
 Assumes strobes are sampled on the rising mclk edge and read data is
 valid one cycle after the read strobe.
*/
`timescale 1ns/1ns
module uip_host_model (
   // Clock
   input wire logic mclk,
   // Register bus
   output logic [2:0] addr,
   output logic rdStb,
   output logic wrStb,
   output logic [7:0] wrData,
   input wire logic [7:0] rdData
);
   initial begin
      addr = 3'h0;
      rdStb = 1'b0;
      wrStb = 1'b0;
      wrData = 8'h00;
   end

   // ==========================================
   // Bus cycles
   task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      addr = a;
      // Reserved enable bits always written as zero
      wrData = (a == uip_pkg::ADDR_IER) ? (d & 8'h3F) : d;
      wrStb = 1'b1;
      @(posedge mclk);
      #1;
      wrStb = 1'b0;
   endtask : wrReg

   // Polling of line status goes through this cycle too
   task automatic rdReg(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1;
      addr = a;
      rdStb = 1'b1;
      @(posedge mclk);
      #1;
      rdStb = 1'b0;
      d = rdData;
   endtask : rdReg
endmodule : uip_host_model

// >>> tb/tb.sv
/*
 Self-checking bench for the interrupt prioritizer.
 Assumes the host model for bus cycles and a 250 MHz mclk.
*/
`timescale 1ns/1ns
module tb;
   localparam logic [2:0] A_DAT = uip_pkg::ADDR_DATA;
   localparam logic [2:0] A_IER = uip_pkg::ADDR_IER;
   localparam logic [2:0] A_ISR = uip_pkg::ADDR_ISR;
   localparam logic [2:0] A_LSR = uip_pkg::ADDR_LSR;
   localparam logic [2:0] A_MSR = uip_pkg::ADDR_MSR;
   localparam int OVR = 0, POP = 1, RXC = 2, XOF = 3, XON = 4, CTS = 5, WAK = 6, SPC = 7;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] addr;
   logic rdStb, wrStb, irq, sleepEnable, pollMode;
   logic [7:0] wrData, rdData, got;
   logic enhEnable = 1'b0, fifoEnable = 1'b0, rxDataPresent = 1'b0, fifoErrAny = 1'b0;
   logic bitTick = 1'b0, thrEmpty = 1'b0, txAllEmpty = 1'b1;
   logic [1:0] rxTrigSel = 2'h0;
   logic [4:0] rxLevel = 5'h00;
   logic [2:0] headErr = 3'h0;
   logic [3:0] msrDelta = 4'h0;
   logic [7:0] evt = 8'h00;
   int badCount = 0, testsRun = 0, cycles = 0;

   always #2 mclk = ~mclk;

   uip_host_model host_u (.mclk(mclk), .addr(addr), .rdStb(rdStb), .wrStb(wrStb),
      .wrData(wrData), .rdData(rdData));

   uip_prioritizer dut_u (.mclk(mclk), .rstn(rstn), .addr(addr), .rdStb(rdStb),
      .wrStb(wrStb), .wrData(wrData), .rdData(rdData), .divLatch(1'b0),
      .enhEnable(enhEnable), .fifoEnable(fifoEnable), .rxTrigSel(rxTrigSel),
      .txTrigSel(2'h0), .rxLevel(rxLevel), .rxDataPresent(rxDataPresent),
      .rxCharEvt(evt[RXC]), .overrunEvt(evt[OVR]), .headErr(headErr),
      .errPopEvt(evt[POP]), .fifoErrAny(fifoErrAny), .bitTick(bitTick),
      .charBits(4'h1), .txLevel(5'h00), .thrEmpty(thrEmpty), .txAllEmpty(txAllEmpty),
      .msrDelta(msrDelta), .xoffEvt(evt[XOF]), .xonEvt(evt[XON]), .specialEvt(evt[SPC]),
      .ctsRtsEvt(evt[CTS]), .wakeEvt(evt[WAK]), .irq(irq), .sleepEnable(sleepEnable),
      .pollMode(pollMode));

   // ==========================================
   // Checks and helpers
   task automatic chkReg(input logic [7:0] e, input logic [7:0] g);
      testsRun++;
      if (g !== e) begin
         badCount++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chkReg

   task automatic chkPin(input logic e, input logic g);
      testsRun++;
      if (g !== e) begin
         badCount++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chkPin

   task automatic rdChk(input logic [2:0] a, input logic [7:0] e);
      host_u.rdReg(a, got);
      chkReg(e, got);
   endtask : rdChk

   task automatic pulse(input int i);
      @(posedge mclk);
      #1;
      evt[i] = 1'b1;
      @(posedge mclk);
      #1;
      evt[i] = 1'b0;
   endtask : pulse

   task automatic waitCyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : waitCyc

   task automatic results;
      $display("comparisons %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   // Hang guard, well above the roughly 160 cycles of the sequence
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         badCount++;
         results();
      end
   end

   // ==========================================
   // Test sequence
   initial begin
      repeat (6) @(posedge mclk);
      #1;
      rstn = 1'b1;
      rdChk(A_IER, 8'h00);
      rdChk(A_ISR, 8'h01);
      chkPin(1'b0, irq);
      fifoEnable = 1'b1;
      #1;
      chkPin(1'b1, pollMode);
      rdChk(A_ISR, 8'hC1);
      $display("done reset");
      rxDataPresent = 1'b1;
      headErr = 3'h5;
      fifoErrAny = 1'b1;
      thrEmpty = 1'b1;
      txAllEmpty = 1'b0;
      rdChk(A_LSR, 8'hB5);
      rxDataPresent = 1'b0;
      headErr = 3'h0;
      fifoErrAny = 1'b0;
      txAllEmpty = 1'b1;
      host_u.wrReg(A_IER, 8'h30);
      rdChk(A_IER, 8'h00);
      enhEnable = 1'b1;
      host_u.wrReg(A_IER, 8'h30);
      rdChk(A_IER, 8'h30);
      chkPin(1'b1, sleepEnable);
      $display("done enables");
      host_u.wrReg(A_IER, 8'h04);
      chkPin(1'b0, pollMode);
      headErr = 3'h1;
      waitCyc(3);
      rdChk(A_ISR, 8'hC1);
      pulse(POP);
      waitCyc(2);
      rdChk(A_ISR, 8'hC6);
      rdChk(A_LSR, 8'h64);
      headErr = 3'h0;
      rdChk(A_ISR, 8'hC1);
      pulse(OVR);
      waitCyc(2);
      chkPin(1'b1, irq);
      rdChk(A_ISR, 8'hC6);
      rdChk(A_LSR, 8'h62);
      rdChk(A_ISR, 8'hC1);
      waitCyc(2);
      chkPin(1'b0, irq);
      $display("done line status");
      host_u.wrReg(A_IER, 8'h2F);
      msrDelta = 4'h1;
      pulse(XOF);
      rxTrigSel = 2'h1;
      rxLevel = 5'h04;
      waitCyc(2);
      rdChk(A_ISR, 8'hC4);
      rxLevel = 5'h03;
      waitCyc(2);
      rdChk(A_ISR, 8'hC2);
      rdChk(A_ISR, 8'hC0);
      rdChk(A_MSR, 8'h00);
      msrDelta = 4'h0;
      waitCyc(2);
      rdChk(A_ISR, 8'hD0);
      pulse(XON);
      waitCyc(2);
      rdChk(A_ISR, 8'hC1);
      // Non-FIFO mode: holding register empty edge drives transmit ready
      fifoEnable = 1'b0;
      thrEmpty = 1'b0;
      waitCyc(2);
      thrEmpty = 1'b1;
      waitCyc(3);
      chkPin(1'b1, irq);
      host_u.wrReg(A_DAT, 8'h55);
      waitCyc(2);
      rdChk(A_ISR, 8'h01);
      fifoEnable = 1'b1;
      $display("done priority");
      host_u.wrReg(A_IER, 8'h01);
      rxTrigSel = 2'h3;
      rxLevel = 5'h01;
      rxDataPresent = 1'b1;
      pulse(RXC);
      bitTick = 1'b1;
      waitCyc(10);
      bitTick = 1'b0;
      rdChk(A_ISR, 8'hC1);
      bitTick = 1'b1;
      waitCyc(10);
      bitTick = 1'b0;
      waitCyc(2);
      rdChk(A_ISR, 8'hCC);
      rdChk(A_DAT, 8'h00);
      waitCyc(2);
      rdChk(A_ISR, 8'hC1);
      rxDataPresent = 1'b0;
      $display("done time-out");
      host_u.wrReg(A_IER, 8'h00);
      pulse(WAK);
      waitCyc(2);
      chkPin(1'b1, irq);
      rdChk(A_ISR, 8'hC1);
      waitCyc(2);
      chkPin(1'b0, irq);
      host_u.wrReg(A_IER, 8'h20);
      pulse(SPC);
      waitCyc(2);
      rdChk(A_ISR, 8'hD0);
      pulse(SPC);
      pulse(RXC);
      waitCyc(2);
      rdChk(A_ISR, 8'hC1);
      pulse(CTS);
      waitCyc(2);
      rdChk(A_ISR, 8'hF0);
      $display("done wake and flow");
      results();
   end
endmodule : tb
